// *** src/dgp_pkg.sv ***
package dgp_pkg;

    // ------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_COMP = 2'b01,
        MODE_ATTN = 2'b10
    } dgp_mode_t;

    // ------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_THR = 8'h04;
    localparam logic [7:0] ADDR_RATIO = 8'h08;
    localparam logic [7:0] ADDR_ATK = 8'h0c;
    localparam logic [7:0] ADDR_MKUP = 8'h10;
    localparam logic [7:0] ADDR_REL = 8'h14;
    localparam logic [7:0] ADDR_STAT = 8'h18;
    localparam int CTRL_MODE = 0;
    localparam int CTRL_KEY = 1;
    localparam int CTRL_KNEE = 4;
    localparam int STAT_TRIG = 16;

    // ------------------------------------------------------------
    // Reset values and step-index limits
    // ------------------------------------------------------------
    localparam logic [9:0] THR_MAX = 10'h21c;
    localparam logic [9:0] THR_RST = 10'h21c;
    localparam logic [3:0] RATIO_RST = 4'h0;
    localparam logic [6:0] ATK_MAX = 7'h78;
    localparam logic [6:0] ATK_RST = 7'h00;
    localparam logic [7:0] MKUP_MAX = 8'hb4;
    localparam logic [7:0] MKUP_RST = 8'h00;
    localparam logic [7:0] REL_MAX = 8'h9f;
    localparam logic [7:0] REL_RST = 8'h00;
    localparam logic [2:0] KNEE_MAX = 3'h5;
    localparam logic [2:0] KNEE_RST = 3'h0;

    // ------------------------------------------------------------
    // Arithmetic scaling, levels in tenths of a dB
    // ------------------------------------------------------------
    localparam logic signed [11:0] LVL_SCALE = 12'sh3c3;
    localparam int LVL_SHIFT = 7;
    localparam int KNEE_BASE_SHIFT = 3;
    localparam logic [11:0] GR_MAX = 12'h4b0;
    localparam int INV_SHIFT = 8;
    localparam int MUL_SHIFT = 4;
    localparam int GAIN_Q = 8;
    localparam logic signed [15:0] DB_TO_OCT = 16'sh0044;
    localparam int DB_TO_OCT_SHIFT = 8;
    localparam int ROM_FRAC_W = 4;
    localparam int ROM_ONE_SHIFT = 15;
    localparam int LATENCY = 3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int REL_MIN_MS = 6;
    localparam int REL_OCT_Q10 = 83;
    localparam int REL_OCT_SHIFT = 10;

    // ------------------------------------------------------------
    // Ratio tables: 1.0 1.1 1.3 1.5 1.7 2 2.5 3 3.5 4 5 6 8 10 20 inf
    // ------------------------------------------------------------
    localparam logic [8:0] RATIO_INV_Q8 [16] = '{
        9'h000, 9'h017, 9'h03b, 9'h055, 9'h069, 9'h080, 9'h09a, 9'h0ab,
        9'h0b7, 9'h0c0, 9'h0cd, 9'h0d5, 9'h0e0, 9'h0e6, 9'h0f3, 9'h100};
    localparam logic [11:0] RATIO_MUL_Q4 [16] = '{
        12'h000, 12'h002, 12'h005, 12'h008, 12'h00b, 12'h010, 12'h018,
        12'h020, 12'h028, 12'h030, 12'h040, 12'h050, 12'h070, 12'h090,
        12'h130, 12'hfff};

    // Fraction of an octave to linear gain, Q15
    localparam logic [15:0] GAIN_FRAC_Q15 [16] = '{
        16'h8000, 16'h85ab, 16'h8b96, 16'h91c4, 16'h9838, 16'h9ef5,
        16'ha5ff, 16'had58, 16'hb505, 16'hbd09, 16'hc567, 16'hce25,
        16'hd745, 16'he0cd, 16'heac1, 16'hf525};

endpackage

// *** src/dgp_rom_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface dgp_rom_if;
    logic rd_en;
    logic [3:0] addr;
    logic [15:0] data;
    modport req (output rd_en, output addr, input data);
    modport rom (input rd_en, input addr, output data);
endinterface

`default_nettype wire

// *** src/dgp_gain_rom.sv ***
`timescale 1ns/1ps
`default_nettype none

module dgp_gain_rom (
    input wire logic ref_clk,
    input wire logic nrst,
    dgp_rom_if.rom port
);
    logic [15:0] data_q;
    logic [15:0] data_d;

    always_comb begin
        data_d = data_q;
        if (port.rd_en) begin
            data_d = dgp_pkg::GAIN_FRAC_Q15[port.addr];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            data_q <= dgp_pkg::GAIN_FRAC_Q15[0];
        end else begin
            data_q <= data_d;
        end
    end

    assign port.data = data_q;
endmodule

`default_nettype wire

// *** src/dgp_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module dgp_top #(
    parameter int DW = 24,
    parameter int SAMPLE_RATE_HZ = 48000
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic s_valid,
    input wire logic [DW-1:0] in_sample,
    input wire logic [DW-1:0] key_sample,
    output logic [DW-1:0] out_sample,
    output logic out_valid
);
    // ------------------------------------------------------------
    // Derived constants
    // ------------------------------------------------------------
    localparam int SPMS = SAMPLE_RATE_HZ / 1000;
    localparam int REL_BASE = $clog2(dgp_pkg::REL_MIN_MS * SPMS);
    localparam logic signed [11:0] FS_CODE = 12'((DW - 1) * 8);

    generate
        if (DW < 8 || DW > 32 || SPMS < 1 || SPMS > 500) begin : g_bad
            $error("dgp_top: DW or SAMPLE_RATE_HZ out of range");
        end
    endgenerate

    function automatic logic [4:0] msb32(input logic [31:0] v);
        logic [4:0] p;
        p = 5'h0;
        for (int i = 0; i < 32; i++) begin
            if (v[i]) begin
                p = 5'(i);
            end
        end
        return p;
    endfunction

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    dgp_pkg::dgp_mode_t mode_q, mode_d;
    logic key_sel_q, key_sel_d;
    logic [2:0] knee_q, knee_d;
    logic [9:0] thr_q, thr_d;
    logic [3:0] ratio_q, ratio_d;
    logic [6:0] atk_q, atk_d;
    logic [7:0] mkup_q, mkup_d;
    logic [7:0] rel_q, rel_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic [19:0] g_q, g_d;
    logic trig_q, trig_d;
    logic wr_go;

    always_comb begin
        mode_d = mode_q;
        key_sel_d = key_sel_q;
        knee_d = knee_q;
        thr_d = thr_q;
        ratio_d = ratio_q;
        atk_d = atk_q;
        mkup_d = mkup_q;
        rel_d = rel_q;
        prdata_d = prdata_q;
        pslverr_d = 1'b0;
        pready_d = psel && penable && !pready_q;
        wr_go = psel && penable && pready_q && pwrite;
        if (pready_d) begin
            prdata_d = 32'h0000_0000;
            case (paddr)
                dgp_pkg::ADDR_CTRL: begin
                    prdata_d[dgp_pkg::CTRL_MODE] =
                        (mode_q == dgp_pkg::MODE_ATTN);
                    prdata_d[dgp_pkg::CTRL_KEY] = key_sel_q;
                    prdata_d[dgp_pkg::CTRL_KNEE +: 3] = knee_q;
                end
                dgp_pkg::ADDR_THR: prdata_d[9:0] = thr_q;
                dgp_pkg::ADDR_RATIO: prdata_d[3:0] = ratio_q;
                dgp_pkg::ADDR_ATK: prdata_d[6:0] = atk_q;
                dgp_pkg::ADDR_MKUP: prdata_d[7:0] = mkup_q;
                dgp_pkg::ADDR_REL: prdata_d[7:0] = rel_q;
                dgp_pkg::ADDR_STAT: begin
                    prdata_d[11:0] = g_q[19:8];
                    prdata_d[dgp_pkg::STAT_TRIG] = trig_q;
                end
                default: pslverr_d = 1'b1;
            endcase
        end
        // Out-of-range indices clamp to the last step
        if (wr_go) begin
            case (paddr)
                dgp_pkg::ADDR_CTRL: begin
                    mode_d = pwdata[dgp_pkg::CTRL_MODE] ?
                        dgp_pkg::MODE_ATTN : dgp_pkg::MODE_COMP;
                    key_sel_d = pwdata[dgp_pkg::CTRL_KEY];
                    knee_d = (pwdata[dgp_pkg::CTRL_KNEE +: 3] >
                        dgp_pkg::KNEE_MAX) ? dgp_pkg::KNEE_MAX :
                        pwdata[dgp_pkg::CTRL_KNEE +: 3];
                end
                dgp_pkg::ADDR_THR: thr_d = (pwdata[9:0] > dgp_pkg::THR_MAX) ?
                    dgp_pkg::THR_MAX : pwdata[9:0];
                dgp_pkg::ADDR_RATIO: ratio_d = pwdata[3:0];
                dgp_pkg::ADDR_ATK: atk_d = (pwdata[6:0] > dgp_pkg::ATK_MAX) ?
                    dgp_pkg::ATK_MAX : pwdata[6:0];
                dgp_pkg::ADDR_MKUP: mkup_d = (pwdata[7:0] > dgp_pkg::MKUP_MAX) ?
                    dgp_pkg::MKUP_MAX : pwdata[7:0];
                dgp_pkg::ADDR_REL: rel_d = (pwdata[7:0] > dgp_pkg::REL_MAX) ?
                    dgp_pkg::REL_MAX : pwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mode_q <= dgp_pkg::MODE_COMP;
            key_sel_q <= 1'b0;
            knee_q <= dgp_pkg::KNEE_RST;
            thr_q <= dgp_pkg::THR_RST;
            ratio_q <= dgp_pkg::RATIO_RST;
            atk_q <= dgp_pkg::ATK_RST;
            mkup_q <= dgp_pkg::MKUP_RST;
            rel_q <= dgp_pkg::REL_RST;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            mode_q <= mode_d;
            key_sel_q <= key_sel_d;
            knee_q <= knee_d;
            thr_q <= thr_d;
            ratio_q <= ratio_d;
            atk_q <= atk_d;
            mkup_q <= mkup_d;
            rel_q <= rel_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // ------------------------------------------------------------
    // Detector, gain computer, smoothing and output stage
    // ------------------------------------------------------------
    dgp_rom_if rom_bus();

    dgp_gain_rom u_rom (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .port(rom_bus)
    );

    logic [DW-1:0] src, mag;
    logic [4:0] mpos, atk_sh, rel_sh, sh;
    logic [31:0] nrm, red, sq, atk_samp;
    logic [7:0] code;
    logic signed [23:0] prod_l, gl;
    logic signed [15:0] lvl, thr_db, over, x, xk, half, gdb;
    logic [15:0] eff;
    logic [11:0] tgt;
    logic [19:0] tq;
    logic signed [20:0] dlt, step;
    logic signed [7:0] e_q, e_d;
    logic [DW-1:0] smp1_q, smp1_d, smp2_q, smp2_d, out_q, out_d;
    logic v1_q, v1_d, v2_q, v2_d, ov_q, ov_d;
    logic signed [DW+16:0] prod, res;
    logic [5:0] shamt;

    always_comb begin
        src = key_sel_q ? key_sample : in_sample;
        mag = src[DW-1] ? (~src + 1'b1) : src;
        mpos = msb32(32'(mag));
        nrm = 32'(mag) << (5'h1f - mpos);
        code = {mpos, nrm[30:28]};
        prod_l = ($signed({4'h0, code}) - FS_CODE) * dgp_pkg::LVL_SCALE;
        lvl = 16'(prod_l >>> dgp_pkg::LVL_SHIFT);
        thr_db = $signed({6'h00, thr_q}) - $signed({6'h00, dgp_pkg::THR_MAX});
        over = lvl - thr_db;
        // Expander works on distance below threshold
        x = (mode_q == dgp_pkg::MODE_ATTN) ? -over : over;
        half = 16'(32'h1 << (32'(knee_q) + dgp_pkg::KNEE_BASE_SHIFT - 1));
        xk = x + half;
        sq = 32'(xk[8:0]) * 32'(xk[8:0]);
        // Quadratic blend keeps the slope continuous at both knee edges
        if (knee_q == 3'h0) begin
            eff = x[15] ? 16'h0000 : x;
        end else if (x <= -half) begin
            eff = 16'h0000;
        end else if (x >= half) begin
            eff = x;
        end else begin
            eff = 16'(sq >> (32'(knee_q) + dgp_pkg::KNEE_BASE_SHIFT + 1));
        end
        case (mode_q)
            dgp_pkg::MODE_COMP: red = (32'(eff) *
                32'(dgp_pkg::RATIO_INV_Q8[ratio_q])) >> dgp_pkg::INV_SHIFT;
            dgp_pkg::MODE_ATTN: red = (32'(eff) *
                32'(dgp_pkg::RATIO_MUL_Q4[ratio_q])) >> dgp_pkg::MUL_SHIFT;
            default: red = 32'h0000_0000;
        endcase
        tgt = (red > 32'(dgp_pkg::GR_MAX)) ? dgp_pkg::GR_MAX : red[11:0];
        tq = {tgt, 8'h00};
        // One-pole ramp: shift sets the time constant in samples
        atk_samp = 32'(atk_q) * 32'(SPMS);
        atk_sh = (atk_q == 7'h00) ? 5'h00 : 5'(msb32(atk_samp) + 5'h01);
        rel_sh = 5'(REL_BASE + ((32'(rel_q) * dgp_pkg::REL_OCT_Q10) >>
            dgp_pkg::REL_OCT_SHIFT));
        dlt = $signed({1'b0, tq}) - $signed({1'b0, g_q});
        sh = (dlt > 21'sh0) ? atk_sh : rel_sh;
        step = dlt >>> sh;
        if (step == 21'sh0 && dlt != 21'sh0) begin
            step = (dlt > 21'sh0) ? 21'sh1 : -21'sh1;
        end
        g_d = g_q;
        trig_d = trig_q;
        smp1_d = smp1_q;
        if (s_valid) begin
            g_d = 20'($signed({1'b0, g_q}) + step);
            trig_d = (tgt != 12'h000);
            smp1_d = in_sample;
        end
        v1_d = s_valid;
        // Stage 1: net gain in dB to octaves, fraction goes to the table
        gdb = $signed({8'h00, mkup_q}) - $signed({4'h0, g_q[19:8]});
        gl = gdb * dgp_pkg::DB_TO_OCT;
        e_d = 8'(gl >>> (dgp_pkg::DB_TO_OCT_SHIFT + dgp_pkg::ROM_FRAC_W));
        rom_bus.addr = gl[dgp_pkg::DB_TO_OCT_SHIFT +: 4];
        rom_bus.rd_en = v1_q;
        smp2_d = smp1_q;
        v2_d = v1_q;
        // Stage 2: scale and saturate rather than wrap
        prod = $signed(smp2_q) * $signed({1'b0, rom_bus.data});
        shamt = 6'(8'(dgp_pkg::ROM_ONE_SHIFT) - e_q);
        res = prod >>> shamt;
        out_d = out_q;
        if (v2_q) begin
            if (res[DW+16:DW-1] != {(DW+17-DW+1){res[DW+16]}}) begin
                out_d = {res[DW+16], {(DW-1){~res[DW+16]}}};
            end else begin
                out_d = res[DW-1:0];
            end
        end
        ov_d = v2_q;
    end

    // No state is shared: one instance per mixer path
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            g_q <= 20'h0_0000;
            trig_q <= 1'b0;
            e_q <= 8'sh00;
            smp1_q <= '0;
            smp2_q <= '0;
            out_q <= '0;
            v1_q <= 1'b0;
            v2_q <= 1'b0;
            ov_q <= 1'b0;
        end else begin
            g_q <= g_d;
            trig_q <= trig_d;
            e_q <= e_d;
            smp1_q <= smp1_d;
            smp2_q <= smp2_d;
            out_q <= out_d;
            v1_q <= v1_d;
            v2_q <= v2_d;
            ov_q <= ov_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign out_sample = out_q;
    assign out_valid = ov_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_take;
        s_valid;
    endsequence
    sequence s_deliver;
        ##3 out_valid;
    endsequence

    a_sample_latency: assert property (s_take |-> s_deliver)
        else $error("sample not delivered three cycles later");
    a_comp_unity: assert property (s_valid && mode_q == dgp_pkg::MODE_COMP
        && knee_q == 3'h0 && over < 16'sh0 |-> tgt == 12'h000)
        else $error("reduction below threshold");
    a_comp_slope: assert property (s_valid && mode_q == dgp_pkg::MODE_COMP
        && ratio_q == 4'h5 && knee_q == 3'h0 && over >= 16'sh0
        && over < 16'sh0400 |-> tgt == 12'(over >>> 1))
        else $error("ratio 2 slope wrong");
    a_comp_limit: assert property (s_valid && mode_q == dgp_pkg::MODE_COMP
        && ratio_q == 4'hf && knee_q == 3'h0 && over >= 16'sh0
        && over < 16'sh0400 |-> tgt == 12'(over))
        else $error("limiter does not hold threshold");
    a_attn_unity: assert property (s_valid && mode_q == dgp_pkg::MODE_ATTN
        && knee_q == 3'h0 && over > 16'sh0 |-> tgt == 12'h000)
        else $error("attenuation above threshold");
    a_attn_slope: assert property (s_valid && mode_q == dgp_pkg::MODE_ATTN
        && ratio_q == 4'h5 && knee_q == 3'h0 && over <= 16'sh0
        && over > -16'sh0400 |-> tgt == 12'(-over))
        else $error("ratio 1:2 slope wrong");
    a_knee_early: assert property (s_valid && knee_q == 3'h5
        && ratio_q == 4'hf && mode_q == dgp_pkg::MODE_COMP
        && over < 16'sh0 && over > -16'sh0040 |-> tgt != 12'h000)
        else $error("soft knee does not start below threshold");
    a_fast_attack: assert property (s_valid && atk_q == 7'h00 && tq > g_q
        |=> g_q == $past(tq))
        else $error("zero attack not immediate");
    a_release_step: assert property (s_valid && tq < g_q
        |=> g_q < $past(g_q) && g_q >= $past(tq))
        else $error("release does not move toward target");
    a_reg_limits: assert property (thr_q <= dgp_pkg::THR_MAX
        && mkup_q <= dgp_pkg::MKUP_MAX && rel_q <= dgp_pkg::REL_MAX
        && atk_q <= dgp_pkg::ATK_MAX)
        else $error("setting index beyond its range");
    a_apb_ready: assert property (psel && penable && !pready |=> pready)
        else $error("apb access not answered in one wait cycle");
endmodule

`default_nettype wire

// *** test/dgp_src_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module dgp_src_model #(
    parameter int DW = 24
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic en,
    input wire logic slow,
    input wire logic [DW-1:0] lvl_in,
    input wire logic [DW-1:0] lvl_key,
    output logic s_valid,
    output logic [DW-1:0] in_sample,
    output logic [DW-1:0] key_sample
);
    // ------------------------------------------------------------
    // Channel path and trigger source
    // ------------------------------------------------------------
    logic neg;

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_valid <= 1'b0;
            in_sample <= '0;
            key_sample <= '0;
        end else if (en && (!slow || $urandom_range(1, 0) == 1)) begin
            neg = ($urandom_range(1, 0) == 1);
            s_valid <= 1'b1;
            in_sample <= neg ? -lvl_in : lvl_in;
            key_sample <= neg ? -lvl_key : lvl_key;
        end else begin
            // Idle lines toggle so a stale value never looks valid
            s_valid <= 1'b0;
            in_sample <= ~in_sample;
            key_sample <= ~key_sample;
        end
    end
endmodule

`default_nettype wire

// *** test/dynamics_gain_processor_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module dynamics_gain_processor_tb_top;
    localparam int DW = 24;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd_q, rnd;
    logic pready, pslverr, err_q, s_valid, out_valid;
    logic en = 1'b0;
    logic slow = 1'b0;
    logic [DW-1:0] lvl_in = '0;
    logic [DW-1:0] lvl_key = '0;
    logic [DW-1:0] in_sample, key_sample, out_sample, want_in;
    logic [DW-1:0] q[$];
    logic [11:0] g, g5;
    int n_errors = 0;
    int checks_done = 0;
    int n_smp = 0;
    int chk = 0;
    localparam logic [7:0] TA [6] = '{dgp_pkg::ADDR_THR, dgp_pkg::ADDR_ATK,
        dgp_pkg::ADDR_REL, dgp_pkg::ADDR_MKUP, dgp_pkg::ADDR_CTRL,
        dgp_pkg::ADDR_STAT};
    localparam logic [31:0] TW [6] = '{32'h0000_03ff, 32'h0000_007f,
        32'h0000_00ff, 32'h0000_00ff, 32'h0000_0070, 32'h0001_0fff};
    localparam logic [31:0] TE [6] = '{32'h0000_021c, 32'h0000_0078,
        32'h0000_009f, 32'h0000_00b4, 32'h0000_0050, 32'h0000_0000};

    always #4 ref_clk = ~ref_clk;

    dgp_top #(.DW(DW)) uut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .s_valid(s_valid), .in_sample(in_sample), .key_sample(key_sample),
        .out_sample(out_sample), .out_valid(out_valid));

    dgp_src_model #(.DW(DW)) u_src (.ref_clk(ref_clk), .nrst(nrst),
        .en(en), .slow(slow), .lvl_in(lvl_in), .lvl_key(lvl_key),
        .s_valid(s_valid), .in_sample(in_sample), .key_sample(key_sample));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [DW-1:0] mag(input logic [DW-1:0] v);
        return v[DW-1] ? -v : v;
    endfunction

    task automatic check(input string nm, input logic [31:0] seen,
            input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", nm, want, seen);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        rd_q = prdata;
        err_q = pslverr;
        if (n >= 64) n_errors++;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so a following call never reassigns psel at once
        @(posedge ref_clk);
    endtask

    task automatic do_reset;
        nrst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
    endtask

    task automatic wait_smp(input int t);
        repeat (2000) if (n_smp < t) @(posedge ref_clk);
        if (n_smp < t) n_errors++;
    endtask

    // Settle first so in-flight samples of the old level are not judged
    task automatic stream(input int n, input logic [DW-1:0] a,
            input logic [DW-1:0] k, input int c);
        chk = 0;
        lvl_in <= a;
        lvl_key <= k;
        slow <= ($urandom_range(1, 0) == 1);
        en <= 1'b1;
        wait_smp(n_smp + 8);
        chk = c;
        wait_smp(n_smp + n);
        en <= 1'b0;
        repeat (5) @(posedge ref_clk);
        chk = 0;
        apb(1'b0, dgp_pkg::ADDR_STAT, 32'h0000_0000);
        g = rd_q[11:0];
    endtask

    always @(posedge ref_clk) begin
        if (s_valid === 1'b1) begin
            q.push_back(in_sample);
            n_smp++;
        end
        if (out_valid === 1'b1 && q.size() > 0) begin
            want_in = q.pop_front();
            case (chk)
                1: check("unity", 32'(out_sample), 32'(want_in));
                2: check("cut", 32'(mag(out_sample) < mag(want_in)), 1);
                3: check("gain", 32'(mag(out_sample) > 7 * mag(want_in)), 1);
                default: ;
            endcase
        end
    end

    initial begin
        #(200000);
        n_errors++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h0000_c54f));
        do_reset();
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, TA[i], TW[i]);
            apb(1'b0, TA[i], 32'h0000_0000);
            check("clamp", rd_q, TE[i]);
        end
        apb(1'b1, 8'h1c, 32'h0000_0001);
        check("unmapped err", 32'(err_q), 1);
        rnd = 32'($urandom_range(540, 0));
        apb(1'b1, dgp_pkg::ADDR_THR, rnd);
        apb(1'b0, dgp_pkg::ADDR_THR, 32'h0000_0000);
        check("thr random", rd_q, rnd);
        do_reset();
        apb(1'b0, dgp_pkg::ADDR_THR, 32'h0000_0000);
        check("thr after reset", rd_q, 32'(dgp_pkg::THR_RST));
        $display("test registers done");
        apb(1'b1, dgp_pkg::ADDR_RATIO, 32'h0000_000f);
        stream(30, 24'h30_0000 | 24'($urandom_range(65535, 0)),
            24'h00_0000, 1);
        $display("test below threshold done");
        apb(1'b1, dgp_pkg::ADDR_THR, 32'h0000_0000);
        for (int r = 0; r < 16; r++) begin
            apb(1'b1, dgp_pkg::ADDR_RATIO, 32'(r));
            stream(4, 24'h40_0000, 24'h00_0000, (r == 0) ? 1 : 2);
            if (r == 0) check("ratio one", 32'(g), 0);
            if (r == 5) g5 = g;
            if (r > 0) check("trig", 32'(rd_q[dgp_pkg::STAT_TRIG]), 1);
        end
        check("limiter", 32'(g >= 12'd400 && g <= 12'd560), 1);
        check("half", 32'(2 * g5 + 40 >= g && 2 * g5 <= g + 40), 1);
        g5 = g;
        stream(200, 24'h00_0100, 24'h00_0000, 0);
        check("release", 32'(g < g5 && g > 0), 1);
        apb(1'b1, dgp_pkg::ADDR_ATK, 32'h0000_0078);
        stream(8, 24'h40_0000, 24'h00_0000, 0);
        check("slow attack", 32'(g < 12'd470), 1);
        $display("test ratios done");
        do_reset();
        apb(1'b1, dgp_pkg::ADDR_THR, 32'h0000_0000);
        apb(1'b1, dgp_pkg::ADDR_RATIO, 32'h0000_000f);
        apb(1'b1, dgp_pkg::ADDR_CTRL, 32'h0000_0002);
        stream(20, 24'h40_0000, 24'h00_0010, 1);
        apb(1'b1, dgp_pkg::ADDR_CTRL, 32'h0000_0000);
        stream(20, 24'h40_0000, 24'h00_0010, 2);
        $display("test key source done");
        do_reset();
        apb(1'b1, dgp_pkg::ADDR_THR, 32'h0000_0186);
        apb(1'b1, dgp_pkg::ADDR_RATIO, 32'h0000_000f);
        stream(10, 24'h10_0000, 24'h00_0000, 1);
        check("hard knee", 32'(g), 0);
        apb(1'b1, dgp_pkg::ADDR_CTRL, 32'h0000_0050);
        stream(10, 24'h10_0000, 24'h00_0000, 2);
        check("soft knee", 32'(g > 0), 1);
        $display("test knee done");
        do_reset();
        apb(1'b1, dgp_pkg::ADDR_CTRL, 32'h0000_0001);
        apb(1'b1, dgp_pkg::ADDR_THR, 32'h0000_0186);
        apb(1'b1, dgp_pkg::ADDR_RATIO, 32'h0000_0005);
        stream(20, 24'h70_0000, 24'h00_0000, 1);
        check("attn above", 32'(g), 0);
        stream(20, 24'h10_0000, 24'h00_0000, 2);
        check("attn below", 32'(g >= 12'd15 && g <= 12'd45), 1);
        g5 = g;
        stream(20, 24'h70_0000, 24'h00_0000, 0);
        check("attn release", 32'(g < g5 && g > 0), 1);
        $display("test expander done");
        do_reset();
        apb(1'b1, dgp_pkg::ADDR_MKUP, 32'h0000_00b4);
        stream(20, 24'h01_0000 | 24'($urandom_range(255, 0)),
            24'h00_0000, 3);
        check("pairing", 32'(q.size()), 0);
        $display("test output gain done");
        give_verdict();
    end
endmodule

`default_nettype wire
